// ==== dv/dsp_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// x and y data memories, one-cycle read
// ****************************************
module dsp_mem_model
(
  input  wire logic              aclk,
  input  wire dsp_pkg::mem_req_t xmem_i,
  output logic [23:0]            xmem_rdata = 24'h000000,
  input  wire dsp_pkg::mem_req_t ymem_i,
  output logic [23:0]            ymem_rdata = 24'h000000
);
  import dsp_pkg::*;
  // word follows its address; released data toggles every cycle
  always @(posedge aclk)
  begin
    xmem_rdata <= xmem_i.req ? {8'hC3, xmem_i.addr} : ~xmem_rdata;
    ymem_rdata <= ymem_i.req ? {8'h3C, ymem_i.addr} : ~ymem_rdata;
  end
endmodule
`default_nettype wire

// ==== dv/test_dsp_mac_and_max_datapath.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dsp_defines.svh"
module test_dsp_mac_and_max_datapath;
  import dsp_pkg::*;
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h00000000;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  mem_req_t    xm;
  mem_req_t    ym;
  logic [23:0] xrd;
  logic [23:0] yrd;
  int          bad_count     = 0;
  int          compares      = 0;
  logic [23:0] tv [4]        = '{24'h000005, 24'h000009, 24'h000007, 24'h7FFFFF};
  logic [23:0] sv [4]        = '{24'h000009, 24'h000005, 24'h000007, 24'h800000};
  logic [23:0] t;
  logic [23:0] s;
  logic [15:0] last;
  logic [15:0] rp2;
  logic [47:0] pe;
  logic        tk;
  logic        mv;

  // ****************************************
  // clock, design and memories
  // ****************************************
  always #2 aclk = ~aclk;

  dsp_mac_max_datapath DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .xmem_o(xm), .xmem_rdata(xrd), .ymem_o(ym), .ymem_rdata(yrd));

  dsp_mem_model mem (.aclk(aclk), .xmem_i(xm), .xmem_rdata(xrd), .ymem_i(ym), .ymem_rdata(yrd));

  // ****************************************
  // comparison, bus tasks and closing
  // ****************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // write: both halves offered at once, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
    int n;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid === 1'b1) && n < 64);
    check(s_axi_bvalid, 1'b1);
    check(s_axi_bresp, er);
  endtask

  task automatic rdraw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid === 1'b1) && n < 64);
    check(s_axi_rvalid, 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'h00FFFFFF,
                       input logic [1:0] er = `RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    rdraw(a, d, r);
    check(d & m, e & m);
    check(r, er);
  endtask

  // poll the busy bit under a bound
  task automatic idle;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do
    begin
      rdraw(`OFF_STATUS, d, r);
      n++;
    end
    while (d[0] !== 1'b0 && n < 20);
    check(d[0], 1'b0);
  endtask

  task automatic run(input logic [15:0] c);
    wr(`OFF_CMD, {16'h0000, c});
    idle();
  endtask

  // flags of target minus source: {n, v, z, c}
  function automatic logic [3:0] flags(input logic [23:0] ft, input logic [23:0] fs);
    logic [24:0] d;
    logic        v;
    d = {1'b0, ft} - {1'b0, fs};
    v = (ft[23] != fs[23]) && (d[23] != ft[23]);
    return {v ^ d[23], v, d[23:0] == 24'h000000, ~d[24]};
  endfunction

  task automatic conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // watchdog and test sequence
  // ****************************************
  initial
  begin
    #80000;
    bad_count++;
    conclude();
  end

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // operands, pointers, modifiers, accumulators near the guard bits
    wr(`OFF_X, 32'h00FFFFFE);
    wr(`OFF_Y, 32'h00000003);
    wr(`OFF_RP, 32'h00000100);
    wr(`OFF_RP + 8'h04, 32'h00000200);
    wr(`OFF_RP + 8'h08, 32'h00000180);
    wr(`OFF_RP + 8'h0C, 32'h00000300);
    wr(`OFF_MOD, 32'h00000002);
    wr(`OFF_MOD + 8'h04, 32'h00000004);
    wr(`OFF_MA0_LO, 32'hFFFFFFFF);
    wr(`OFF_MA0_HI, 32'h00007FFF);
    wr(`OFF_MA1_LO, 32'h00000000);
    wr(`OFF_MA1_HI, 32'h00080000);
    wr(`OFF_P_LO, 32'h00000001);
    wr(`OFF_P_HI, 32'h00000000);
    run(16'h0260);
    rdchk(`OFF_MA0_LO, 32'h00000000, 32'hFFFFFFFF);
    rdchk(`OFF_MA0_HI, 32'h00008000, 32'h000FFFFF);
    rdchk(`OFF_P_LO, 32'hFFFFFFFA, 32'hFFFFFFFF);
    rdchk(`OFF_P_HI, 32'h0000FFFF, 32'h0000FFFF);
    rdchk(`OFF_X + 8'h04, 32'h00C30100);
    rdchk(`OFF_Y + 8'h04, 32'h003C0300);
    rdchk(`OFF_RP, 32'h00000102);
    rdchk(`OFF_RP + 8'h0C, 32'h00000304);
    rdchk(`OFF_STATUS, 32'h00000002, 32'h0000000F);
    // bank 1 with signed overflow of the guard bits
    run(16'h0184);
    rdchk(`OFF_MA1_LO, 32'hFFFFFFFA, 32'hFFFFFFFF);
    rdchk(`OFF_MA1_HI, 32'h0007FFFF, 32'h000FFFFF);
    rdchk(`OFF_X, 32'h00C30200);
    rdchk(`OFF_Y, 32'h003C0304);
    rdchk(`OFF_RP + 8'h04, 32'h00000204);
    rdchk(`OFF_STATUS, 32'h0000000E, 32'h0000000F);
    // bank 0 without guard entry: sticky flag kept
    wr(`OFF_MA0_HI, 32'h00000000);
    wr(`OFF_MA0_LO, 32'h00000000);
    run(16'h0000);
    pe = $signed(24'hC30200) * $signed(24'h3C0304);
    rdchk(`OFF_P_LO, pe[31:0], 32'hFFFFFFFF);
    rdchk(`OFF_P_HI, {16'h0000, pe[47:32]}, 32'h0000FFFF);
    rdchk(`OFF_STATUS, 32'h0000000C, 32'h0000000F);
    rdchk(`OFF_LAST, 32'h00000102);
    wr(`OFF_STATUS, 32'h00000008);
    rdchk(`OFF_STATUS, 32'h00000004, 32'h0000000F);
    last = 16'h0102;
    rp2  = 16'h0180;
    // maximum load, plain then with move, over the compare cases
    for (int k = 0; k < 8; k++)
    begin
      mv = (k >= 4);
      t  = tv[k % 4];
      s  = sv[k % 4];
      tk = $signed(s) >= $signed(t);
      wr(`OFF_ACC, {8'h00, t});
      wr(`OFF_ACC + 8'h04, {8'h00, s});
      wr(`OFF_RP + 8'h0C, 32'h00000BAD);
      run(mv ? 16'h9002 : 16'h9001);
      rdchk(`OFF_ACC, {8'h00, tk ? s : t});
      rdchk(`OFF_ACC + 8'h04, {8'h00, mv ? {8'hC3, rp2} : s});
      rdchk(`OFF_RP + 8'h0C, {16'h0000, tk ? last : 16'h0BAD});
      rdchk(`OFF_STATUS, {24'h000000, flags(t, s), 4'h0}, 32'h000000F0);
      if (mv)
      begin
        last = rp2;
        rp2  = rp2 + 16'h0002;
        rdchk(`OFF_RP + 8'h08, {16'h0000, rp2});
      end
    end
    // refused accesses: unmapped, read-only, busy
    rdchk(8'h5C, 32'h00000000, 32'hFFFFFFFF, `RESP_SLV);
    wr(`OFF_LAST, 32'h00001234, `RESP_SLV);
    wr(`OFF_CMD, 32'h00009001);
    wr(`OFF_ACC, 32'h00000001, `RESP_SLV);
    idle();
    rdchk(`OFF_ACC, 32'h007FFFFF);
    conclude();
  end
endmodule
`default_nettype wire

// ==== src/dsp_defines.svh ====
// How it works
// - multiply-add adds product register into the selected 52-bit accumulator
// - same op multiplies selected x and y operands into the product register
// - same op loads one x-memory and one y-memory word into 24-bit operands
// - x address from selected pointer 0 or 1, y address from pointer 3, both then post-modified
// - guard entry flag set on overflow into guard bits, else cleared
// - sticky guard overflow flag set on guard overflow, else kept
// - only the entry flag of the selected accumulator bank is updated
// - max load copies operand and latches previous address only when operand >= target
// - max flags come from target minus operand, negative is overflow xor msb
// - max with move copies source and latches previous address when source >= target
// - max with move loads a memory word into the compared source accumulator
// - max with move flags come from target minus source, same definitions
`ifndef DSP_DEFINES_SVH
`define DSP_DEFINES_SVH
// ****************************************
// register byte offsets
// ****************************************
`define OFF_CMD    8'h00
`define OFF_STATUS 8'h04
`define OFF_MA0_LO 8'h08
`define OFF_MA0_HI 8'h0C
`define OFF_MA1_LO 8'h10
`define OFF_MA1_HI 8'h14
`define OFF_P_LO   8'h18
`define OFF_P_HI   8'h1C
`define OFF_X      8'h20
`define OFF_Y      8'h28
`define OFF_ACC    8'h30
`define OFF_RP     8'h40
`define OFF_MOD    8'h50
`define OFF_LAST   8'h58
`define MASK_PAIR  8'hF8
`define MASK_QUAD  8'hF0
// ****************************************
// command fields and codes
// ****************************************
`define OP_MAC      2'h0
`define OP_MAX      2'h1
`define OP_MAX_MOVE 2'h2
`define STAT_MV_BIT 3
// ****************************************
// reset values and bus answers
// ****************************************
`define RST_WORD  32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLV  2'h2
`endif

// ==== src/dsp_mac_max_datapath.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dsp_defines.svh"
module dsp_mac_max_datapath
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output dsp_pkg::mem_req_t     xmem_o,
  input  wire logic [23:0]      xmem_rdata,
  output dsp_pkg::mem_req_t     ymem_o,
  input  wire logic [23:0]      ymem_rdata
);
  import dsp_pkg::*;

  dp_state_t   s_reg;
  dp_state_t   s_next;
  cmd_t        cw;
  cmd_t        ncw;
  logic [51:0] p_ext;
  logic [51:0] mac_sum;
  logic        guard_entry;
  logic        guard_over;
  logic [47:0] prod;
  logic [23:0] max_op;
  logic [24:0] diff;
  logic        max_v;
  logic        max_n;
  logic        max_take;

  // ****************************************
  // combinational datapath terms
  // ****************************************
  // accumulate and flag terms of the multiply-add
  assign cw          = s_reg.cmd;
  assign p_ext       = {{4{s_reg.p[47]}}, s_reg.p};
  assign mac_sum     = s_reg.ma[cw.bank] + p_ext;
  assign guard_entry = !((&mac_sum[51:47]) || !(|mac_sum[51:47]));
  assign guard_over  = (s_reg.ma[cw.bank][51] == p_ext[51]) && (mac_sum[51] != p_ext[51]);
  assign prod        = 48'($signed(s_reg.x[cw.x_src]) * $signed(s_reg.y[cw.y_src]));
  // compare terms of the max loads, target minus operand
  assign max_op   = s_reg.acc[cw.src];
  assign diff     = {1'b0, s_reg.acc[cw.tgt]} + {1'b0, ~max_op} + 25'h0000001;
  assign max_v    = (s_reg.acc[cw.tgt][23] != max_op[23]) && (diff[23] != s_reg.acc[cw.tgt][23]);
  assign max_n    = max_v ^ diff[23];
  assign max_take = max_n || (diff[23:0] == 24'h000000);

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // read mux, answer is {resp, data}
  function automatic logic [33:0] rd_mux(input logic [7:0] a);
    logic [33:0] r;
    r = {`RESP_OKAY, `RST_WORD};
    if ((a & `MASK_PAIR) == `OFF_X)
      r[31:0] = {8'h00, s_reg.x[a[2]]};
    else if ((a & `MASK_PAIR) == `OFF_Y)
      r[31:0] = {8'h00, s_reg.y[a[2]]};
    else if ((a & `MASK_QUAD) == `OFF_ACC)
      r[31:0] = {8'h00, s_reg.acc[a[3:2]]};
    else if ((a & `MASK_QUAD) == `OFF_RP)
      r[31:0] = {16'h0000, s_reg.rp[a[3:2]]};
    else if ((a & `MASK_PAIR) == `OFF_MOD)
      r[31:0] = {16'h0000, s_reg.sm[a[2]]};
    else
    begin
      case (a)
        `OFF_CMD:    r[31:0] = {16'h0000, s_reg.cmd};
        `OFF_STATUS: r[31:0] = {24'h000000, s_reg.n, s_reg.v, s_reg.z, s_reg.c, s_reg.mv, s_reg.vm,
                                s_reg.st != ST_IDLE};
        `OFF_MA0_LO: r[31:0] = s_reg.ma[0][31:0];
        `OFF_MA0_HI: r[31:0] = {12'h000, s_reg.ma[0][51:32]};
        `OFF_MA1_LO: r[31:0] = s_reg.ma[1][31:0];
        `OFF_MA1_HI: r[31:0] = {12'h000, s_reg.ma[1][51:32]};
        `OFF_P_LO:   r[31:0] = s_reg.p[31:0];
        `OFF_P_HI:   r[31:0] = {16'h0000, s_reg.p[47:32]};
        `OFF_LAST:   r[31:0] = {16'h0000, s_reg.last_addr};
        default:     r = {`RESP_SLV, `RST_WORD};
      endcase
    end
    return r;
  endfunction

  // ****************************************
  // next-state logic
  // ****************************************
  // bus slave first, then the datapath so its flag sets win over clears
  always_comb
  begin
    logic [31:0] wm;
    logic [33:0] rm;
    logic [7:0]  a;
    logic        busy;
    wm     = `RST_WORD;
    rm     = {`RESP_OKAY, `RST_WORD};
    a      = 8'h00;
    s_next = s_reg;
    busy   = (s_reg.st != ST_IDLE);
    ncw    = s_reg.cmd;
    // read channel
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_reg.arready)
    begin
      s_next.rvalid = 1'b1;
      {s_next.rresp, s_next.rdata} = rd_mux(s_axi_araddr);
    end
    s_next.arready = !s_next.rvalid;
    // write channels, taken in either order
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    if (s_axi_awvalid && s_reg.awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_next.aw_got && s_next.w_got && !s_next.bvalid)
    begin
      a              = s_next.awaddr;
      rm             = rd_mux(a);
      wm             = wmerge(rm[31:0], s_next.wdata, s_next.wstrb);
      s_next.aw_got  = 1'b0;
      s_next.w_got   = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = `RESP_OKAY;
      if (a == `OFF_STATUS)
      begin
        if (wm[`STAT_MV_BIT] && s_next.wstrb[0])
          s_next.mv = 1'b0;
      end
      else if (busy || (rm[33:32] != `RESP_OKAY) || (a == `OFF_LAST))
        s_next.bresp = `RESP_SLV;
      else if ((a & `MASK_PAIR) == `OFF_X)
        s_next.x[a[2]] = wm[23:0];
      else if ((a & `MASK_PAIR) == `OFF_Y)
        s_next.y[a[2]] = wm[23:0];
      else if ((a & `MASK_QUAD) == `OFF_ACC)
        s_next.acc[a[3:2]] = wm[23:0];
      else if ((a & `MASK_QUAD) == `OFF_RP)
        s_next.rp[a[3:2]] = wm[15:0];
      else if ((a & `MASK_PAIR) == `OFF_MOD)
        s_next.sm[a[2]] = wm[15:0];
      else
      begin
        case (a)
          `OFF_CMD:
          begin
            // one command word starts one whole operation
            ncw           = cmd_t'(wm[15:0]);
            s_next.cmd    = ncw;
            s_next.st     = ST_ISSUE;
            s_next.xm.req = (ncw.op == `OP_MAC) || (ncw.op == `OP_MAX_MOVE);
            s_next.ym.req = (ncw.op == `OP_MAC);
            // x from pointer 0/1 (move pointer for max with move), y from pointer 3
            s_next.xm.addr = (ncw.op == `OP_MAX_MOVE) ? s_reg.rp[ncw.move_ptr] :
                             s_reg.rp[{1'b0, ncw.x_pointer_select}];
            s_next.ym.addr = s_reg.rp[3];
          end
          `OFF_MA0_LO: s_next.ma[0][31:0]  = wm;
          `OFF_MA0_HI: s_next.ma[0][51:32] = wm[19:0];
          `OFF_MA1_LO: s_next.ma[1][31:0]  = wm;
          `OFF_MA1_HI: s_next.ma[1][51:32] = wm[19:0];
          `OFF_P_LO:   s_next.p[31:0]      = wm;
          `OFF_P_HI:   s_next.p[47:32]     = wm[15:0];
          default:     s_next.bresp        = `RESP_SLV;
        endcase
      end
    end
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready  = !s_next.w_got && !s_next.bvalid;
    // operation sequencer
    case (s_reg.st)
      ST_IDLE:
      begin
      end
      ST_ISSUE:
      begin
        s_next.xm.req = 1'b0;
        s_next.ym.req = 1'b0;
        s_next.st     = ST_EXEC;
      end
      ST_EXEC:
      begin
        s_next.st = ST_IDLE;
        if (cw.op == `OP_MAC)
        begin
          s_next.ma[cw.bank] = mac_sum;
          s_next.p           = prod;
          s_next.x[cw.x_dst] = xmem_rdata;
          s_next.y[cw.y_dst] = ymem_rdata;
          s_next.vm[cw.bank] = guard_entry;
          if (guard_over)
            s_next.mv = 1'b1;
          s_next.rp[{1'b0, cw.x_pointer_select}] = s_reg.xm.addr + s_reg.sm[cw.x_mod];
          s_next.rp[3]     = s_reg.ym.addr + s_reg.sm[cw.y_mod];
          s_next.last_addr = s_reg.xm.addr;
        end
        else if ((cw.op == `OP_MAX) || (cw.op == `OP_MAX_MOVE))
        begin
          // flags of target minus operand
          s_next.c = diff[24];
          s_next.z = (diff[23:0] == 24'h000000);
          s_next.v = max_v;
          s_next.n = max_n;
          if (cw.op == `OP_MAX_MOVE)
          begin
            // post-modify first so a latch into pointer 3 wins
            s_next.rp[cw.move_ptr] = s_reg.xm.addr + s_reg.sm[cw.x_mod];
            s_next.last_addr       = s_reg.xm.addr;
          end
          if (max_take)
          begin
            s_next.acc[cw.tgt] = max_op;
            s_next.rp[3]       = s_reg.last_addr;
          end
          if (cw.op == `OP_MAX_MOVE)
            s_next.acc[cw.src] = xmem_rdata;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg         <= '0;
      s_reg.st      <= ST_IDLE;
      s_reg.awready <= 1'b1;
      s_reg.wready  <= 1'b1;
      s_reg.arready <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign xmem_o        = s_reg.xm;
  assign ymem_o        = s_reg.ym;

  // ****************************************
  // checks
  // ****************************************
  chk_mac_accum_sum: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC && cw.op == `OP_MAC) |=> s_reg.ma[$past(cw.bank)] == $past(mac_sum))
    else $error("accumulator not updated with sum");
  chk_product_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC && cw.op == `OP_MAC) |=>
      s_reg.p == $past(48'($signed(s_reg.x[cw.x_src]) * $signed(s_reg.y[cw.y_src]))))
    else $error("product register wrong");
  chk_operand_loads: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC && cw.op == `OP_MAC) |=>
      s_reg.x[$past(cw.x_dst)] == $past(xmem_rdata) && s_reg.y[$past(cw.y_dst)] == $past(ymem_rdata))
    else $error("operand load wrong");
  chk_fetch_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_ISSUE && cw.op == `OP_MAC) |->
      xmem_o.req && ymem_o.req && ymem_o.addr == $past(s_reg.rp[3]))
    else $error("fetch address wrong");
  chk_guard_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC && cw.op == `OP_MAC) |=> s_reg.vm[$past(cw.bank)] == $past(guard_entry))
    else $error("guard entry flag wrong");
  chk_guard_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC && cw.op == `OP_MAC && guard_over) |=> s_reg.mv ##1 s_reg.mv || s_axi_bvalid)
    else $error("sticky overflow lost");
  chk_other_bank: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC) |=> s_reg.vm[!$past(cw.bank)] == $past(s_reg.vm[!cw.bank]))
    else $error("wrong bank flag changed");
  chk_max_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC && cw.op == `OP_MAX && !max_take) |=>
      $stable(s_reg.acc) && $stable(s_reg.rp[3]))
    else $error("max load changed state on miss");
  chk_max_take: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC && cw.op != `OP_MAC && max_take && cw.src != cw.tgt) |=>
      s_reg.acc[$past(cw.tgt)] == $past(max_op) && s_reg.rp[3] == $past(s_reg.last_addr))
    else $error("max load did not copy");
  chk_neg_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC && cw.op != `OP_MAC) |=> s_reg.n == (s_reg.v ^ $past(diff[23])))
    else $error("negative flag wrong");
  chk_move_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_EXEC && cw.op == `OP_MAX_MOVE) |=> s_reg.acc[$past(cw.src)] == $past(xmem_rdata))
    else $error("move load wrong");
  chk_one_operation: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.st == ST_IDLE && s_next.st == ST_ISSUE) |=> s_reg.st == ST_ISSUE ##1 s_reg.st == ST_EXEC
      ##1 s_reg.st == ST_IDLE)
    else $error("operation length wrong");
endmodule
`default_nettype wire

// ==== src/dsp_pkg.sv ====
package dsp_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_EXEC} state_t;
  // command word layout
  typedef struct packed {
    logic [1:0] move_ptr;   // pointer for max parallel move
    logic [1:0] src;        // compare source accumulator
    logic [1:0] tgt;        // target accumulator
    logic       y_mod;      // modifier for y pointer
    logic       x_mod;      // modifier for x pointer
    logic       x_pointer_select;
    logic       y_dst;
    logic       x_dst;
    logic       y_src;
    logic       x_src;
    logic       bank;
    logic [1:0] op;
  } cmd_t;
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } mem_req_t;
  typedef struct packed {
    state_t            st;
    cmd_t              cmd;
    logic [1:0][51:0]  ma;
    logic [47:0]       p;
    logic [1:0][23:0]  x;
    logic [1:0][23:0]  y;
    logic [3:0][23:0]  acc;
    logic [3:0][15:0]  rp;
    logic [1:0][15:0]  sm;
    logic [15:0]       last_addr;
    logic [1:0]        vm;
    logic              mv;
    logic              c;
    logic              z;
    logic              v;
    logic              n;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    mem_req_t          xm;
    mem_req_t          ym;
  } dp_state_t;
endpackage
